/* alu3_unit.sv */
// Three-operand integer execution unit with writeback and overflow exception.
//
// Contract
// - 32-bit sum forms add both sources and write the sum to the destination.
// - Trapping 32-bit sum and difference raise overflow on two's complement overflow.
// - Wrapping 32-bit forms never raise overflow and write the wrapped result.
// - In 64-bit mode 32-bit results are sign extended from bit 31.
// - 32-bit difference forms subtract source b from source a and write it.
// - Signed less-than writes 1 when source a is smaller, else 0.
// - Unsigned less-than writes 1 when source a is smaller, else 0.
// - Conjunction writes the bitwise and of both sources.
// - Disjunction writes the bitwise or of both sources.
// - Exclusive writes the bitwise exclusive or of both sources.
// - Not-any writes the inverted bitwise or of both sources.
// - Wide sum forms write the 64-bit sum of both sources.
// - Trapping wide forms raise overflow on 64-bit two's complement overflow.
// - Wrapping wide forms never raise overflow and write the wrapped result.
// - Wide difference forms subtract source b from source a, 64 bits.
`timescale 1ns/1ps
`include "alu3_params.svh"

module alu3_unit import alu3_pkg::*; (
	input logic mclk,
	input logic resetn,
	input logic ce,
	input logic mode64,
	input logic issue_valid,
	input alu3_op_t issue_op,
	input logic [`ALU3_IDX_W-1:0] operand_a_index,
	input logic [`ALU3_IDX_W-1:0] operand_b_index,
	input logic [`ALU3_IDX_W-1:0] dest_index,
	output logic [`ALU3_IDX_W-1:0] rf_a_index,
	output logic [`ALU3_IDX_W-1:0] rf_b_index,
	input logic [`ALU3_XLEN-1:0] rf_a_data,
	input logic [`ALU3_XLEN-1:0] rf_b_data,
	output logic wb_valid,
	output logic [`ALU3_IDX_W-1:0] wb_index,
	output logic [`ALU3_XLEN-1:0] wb_data,
	output logic ovf_exc,
	output logic [`ALU3_IDX_W-1:0] exc_index
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [`ALU3_XLEN-1:0] word_to_reg(input logic [`ALU3_WLEN-1:0] w,
		input logic wide_mode);
		word_to_reg = {(wide_mode ? {`ALU3_WLEN{w[`ALU3_WORD_MSB]}} : {`ALU3_WLEN{1'b0}}), w};
	endfunction : word_to_reg

	function automatic logic is_word_arith(input alu3_op_t op);
		is_word_arith = (op == op_sum32_trap) || (op == op_sum32_wrap) ||
			(op == op_diff32_trap) || (op == op_diff32_wrap);
	endfunction : is_word_arith

	function automatic logic is_wrap_arith(input alu3_op_t op);
		is_wrap_arith = (op == op_sum32_wrap) || (op == op_diff32_wrap) ||
			(op == op_wide_sum_wrap) || (op == op_wide_diff_wrap);
	endfunction : is_wrap_arith

	// ****************************************************************
	// Register file reads
	// ****************************************************************
	// The file is read asynchronously, so source data belongs to the issuing cycle.
	assign rf_a_index = operand_a_index;
	assign rf_b_index = operand_b_index;

	// ****************************************************************
	// Datapath
	// ****************************************************************
	logic sub_sel;
	logic [`ALU3_XLEN-1:0] add_result;
	logic [`ALU3_XLEN-1:0] logic_result;
	logic add_ovf_word;
	logic add_ovf_dword;
	logic add_lt_s;
	logic add_lt_u;

	always_comb begin
		case (issue_op)
			op_diff32_trap, op_diff32_wrap, op_wide_diff_trap, op_wide_diff_wrap,
			op_less_than_signed, op_less_than_unsigned: sub_sel = 1'b1;
			default: sub_sel = 1'b0;
		endcase
	end

	alu3_adder u_adder (
		.a(rf_a_data),
		.b(rf_b_data),
		.sub(sub_sel),
		.result(add_result),
		.ovf_word(add_ovf_word),
		.ovf_dword(add_ovf_dword),
		.lt_signed(add_lt_s),
		.lt_unsigned(add_lt_u)
	);

	alu3_logic u_logic (
		.a(rf_a_data),
		.b(rf_b_data),
		.op(issue_op),
		.result(logic_result)
	);

	// ****************************************************************
	// Result selection and writeback state
	// ****************************************************************
	alu3_state_t state_r;
	alu3_state_t state_nxt;
	logic [`ALU3_XLEN-1:0] res_sel;
	logic trap_hit;
	logic op_known;

	always_comb begin
		res_sel = `ALU3_RST_DATA;
		trap_hit = 1'b0;
		op_known = 1'b1;
		case (issue_op)
			op_sum32_trap, op_diff32_trap: begin
				res_sel = word_to_reg(add_result[`ALU3_WLEN-1:0], mode64);
				trap_hit = add_ovf_word;
			end
			op_sum32_wrap, op_diff32_wrap: begin
				res_sel = word_to_reg(add_result[`ALU3_WLEN-1:0], mode64);
			end
			op_less_than_signed: res_sel = {{(`ALU3_XLEN-1){1'b0}}, add_lt_s};
			op_less_than_unsigned: res_sel = {{(`ALU3_XLEN-1){1'b0}}, add_lt_u};
			op_bitwise_conj, op_bitwise_disj, op_bitwise_exclusive,
			op_bitwise_not_any: res_sel = logic_result;
			op_wide_sum_trap, op_wide_diff_trap: begin
				res_sel = add_result;
				trap_hit = add_ovf_dword;
			end
			op_wide_sum_wrap, op_wide_diff_wrap: res_sel = add_result;
			default: op_known = 1'b0;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.wb_valid = 1'b0;
		state_nxt.ovf_exc = 1'b0;
		if (issue_valid && op_known) begin
			if (trap_hit) begin
				// A trapped result must not reach the file, so only the exception fires.
				state_nxt.ovf_exc = 1'b1;
				state_nxt.exc_index = dest_index;
			end else begin
				state_nxt.wb_valid = 1'b1;
				state_nxt.wb_index = dest_index;
				state_nxt.wb_data = res_sel;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= '{wb_valid: 1'b0, wb_index: `ALU3_RST_IDX, wb_data: `ALU3_RST_DATA,
				ovf_exc: 1'b0, exc_index: `ALU3_RST_IDX};
		end else if (ce) begin
			// A pulse stretches while ce is low; writing the same word twice is harmless.
			state_r <= state_nxt;
		end
	end

	assign wb_valid = state_r.wb_valid;
	assign wb_index = state_r.wb_index;
	assign wb_data = state_r.wb_data;
	assign ovf_exc = state_r.ovf_exc;
	assign exc_index = state_r.exc_index;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [`ALU3_WLEN-1:0] a32_w;
	logic [`ALU3_WLEN-1:0] b32_w;
	logic [`ALU3_WLEN:0] ref_sum33_w;
	logic [`ALU3_WLEN:0] ref_diff33_w;
	logic [`ALU3_XLEN:0] ref_sum65_w;
	logic [`ALU3_XLEN:0] ref_diff65_w;
	logic ref_ovf_w;
	logic go_w;

	assign a32_w = rf_a_data[`ALU3_WLEN-1:0];
	assign b32_w = rf_b_data[`ALU3_WLEN-1:0];
	assign ref_sum33_w = {a32_w[`ALU3_WORD_MSB], a32_w} + {b32_w[`ALU3_WORD_MSB], b32_w};
	assign ref_diff33_w = {a32_w[`ALU3_WORD_MSB], a32_w} - {b32_w[`ALU3_WORD_MSB], b32_w};
	assign ref_sum65_w = {rf_a_data[`ALU3_DWORD_MSB], rf_a_data} +
		{rf_b_data[`ALU3_DWORD_MSB], rf_b_data};
	assign ref_diff65_w = {rf_a_data[`ALU3_DWORD_MSB], rf_a_data} -
		{rf_b_data[`ALU3_DWORD_MSB], rf_b_data};
	assign go_w = issue_valid && ce;

	always_comb begin
		case (issue_op)
			op_sum32_trap: ref_ovf_w = ref_sum33_w[`ALU3_WLEN] != ref_sum33_w[`ALU3_WORD_MSB];
			op_diff32_trap: ref_ovf_w = ref_diff33_w[`ALU3_WLEN] != ref_diff33_w[`ALU3_WORD_MSB];
			op_wide_sum_trap: ref_ovf_w = ref_sum65_w[`ALU3_XLEN] != ref_sum65_w[`ALU3_DWORD_MSB];
			op_wide_diff_trap: ref_ovf_w =
				ref_diff65_w[`ALU3_XLEN] != ref_diff65_w[`ALU3_DWORD_MSB];
			default: ref_ovf_w = 1'b0;
		endcase
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sum_word_data_a: assert property (
		go_w && (issue_op == op_sum32_wrap) |=>
			wb_valid && (wb_data[`ALU3_WLEN-1:0] == $past(a32_w) + $past(b32_w)))
		else $error("Word sum written wrongly.");

	trap_raises_a: assert property (
		go_w && ref_ovf_w |=> ovf_exc && (exc_index == $past(dest_index)))
		else $error("Overflow did not raise the exception.");

	wrap_no_trap_a: assert property (
		go_w && is_wrap_arith(issue_op) |=> !ovf_exc && wb_valid)
		else $error("Wrapping form raised an exception.");

	word_sign_ext_a: assert property (
		go_w && mode64 && is_word_arith(issue_op) && !ref_ovf_w |=>
			wb_data[`ALU3_DWORD_MSB:`ALU3_WLEN] == {`ALU3_WLEN{wb_data[`ALU3_WORD_MSB]}})
		else $error("Word result not sign extended.");

	diff_word_data_a: assert property (
		go_w && (issue_op == op_diff32_wrap) |=>
			wb_data[`ALU3_WLEN-1:0] == $past(a32_w) - $past(b32_w))
		else $error("Word difference written wrongly.");

	lt_signed_a: assert property (
		go_w && (issue_op == op_less_than_signed) |=>
			wb_data == (($signed($past(rf_a_data)) < $signed($past(rf_b_data))) ?
				64'h0000_0000_0000_0001 : 64'h0000_0000_0000_0000))
		else $error("Signed compare wrong.");

	lt_unsigned_a: assert property (
		go_w && (issue_op == op_less_than_unsigned) |=>
			wb_data == (($past(rf_a_data) < $past(rf_b_data)) ?
				64'h0000_0000_0000_0001 : 64'h0000_0000_0000_0000))
		else $error("Unsigned compare wrong.");

	conj_data_a: assert property (
		go_w && (issue_op == op_bitwise_conj) |=> wb_data == ($past(rf_a_data) & $past(rf_b_data)))
		else $error("Conjunction wrong.");

	disj_data_a: assert property (
		go_w && (issue_op == op_bitwise_disj) |=> wb_data == ($past(rf_a_data) | $past(rf_b_data)))
		else $error("Disjunction wrong.");

	excl_data_a: assert property (
		go_w && (issue_op == op_bitwise_exclusive) |=>
			wb_data == ($past(rf_a_data) ^ $past(rf_b_data)))
		else $error("Exclusive disjunction wrong.");

	not_any_data_a: assert property (
		go_w && (issue_op == op_bitwise_not_any) |=>
			wb_data == ~($past(rf_a_data) | $past(rf_b_data)))
		else $error("Inverted disjunction wrong.");

	wide_sum_data_a: assert property (
		go_w && (issue_op == op_wide_sum_wrap) |=>
			wb_data == $past(rf_a_data) + $past(rf_b_data))
		else $error("Wide sum wrong.");

	wide_trap_a: assert property (
		go_w && ((issue_op == op_wide_sum_trap) || (issue_op == op_wide_diff_trap)) |=>
			(ovf_exc == $past(ref_ovf_w)) && (wb_valid == !$past(ref_ovf_w)))
		else $error("Wide overflow not reported correctly.");

	wide_wrap_a: assert property (
		go_w && (issue_op == op_wide_diff_wrap) |=>
			!ovf_exc && (wb_index == $past(dest_index)))
		else $error("Wide wrapping form trapped.");

	wide_diff_data_a: assert property (
		go_w && (issue_op == op_wide_diff_wrap) |=>
			wb_data == $past(rf_a_data) - $past(rf_b_data))
		else $error("Wide difference wrong.");

	trap_no_write_a: assert property (
		ovf_exc |-> !wb_valid)
		else $error("Trapped result reached the file.");

	word_low_only_a: assert property (
		go_w && (issue_op == op_sum32_trap) && !ref_ovf_w |=>
			wb_data[`ALU3_WLEN-1:0] == $past(a32_w) + $past(b32_w))
		else $error("Word sum depends on upper bits.");

	trap_sum_data_a: assert property (
		go_w && (issue_op == op_wide_sum_trap) && !ref_ovf_w |=>
			wb_data == $past(rf_a_data) + $past(rf_b_data))
		else $error("Wide trapping sum wrong.");

	trap_keeps_data_a: assert property (
		go_w && ref_ovf_w |=> !wb_valid && $stable(wb_data))
		else $error("Trapped result changed the written data.");

	word_trap_c: cover property (go_w && (issue_op == op_sum32_trap) ##1 ovf_exc);
	wide_trap_c: cover property (go_w && (issue_op == op_wide_diff_trap) ##1 ovf_exc);
	lt_true_c: cover property (go_w && (issue_op == op_less_than_signed) ##1 wb_data[0]);
	back_to_back_c: cover property (go_w ##1 go_w ##1 wb_valid);
	word_zero_ext_c: cover property (go_w && !mode64 && is_word_arith(issue_op) ##1 wb_valid);

endmodule : alu3_unit

/* alu3_params.svh */
// Constants shared by the three-operand integer unit.
`ifndef ALU3_PARAMS_SVH
`define ALU3_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define ALU3_XLEN 64
`define ALU3_WLEN 32
`define ALU3_IDX_W 5
`define ALU3_OP_W 4
`define ALU3_WORD_MSB 31
`define ALU3_DWORD_MSB 63

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define ALU3_RST_DATA 64'h0000_0000_0000_0000
`define ALU3_RST_IDX 5'h00
`define ALU3_LATENCY 1

`endif

/* alu3_pkg.sv */
// Types of the three-operand integer unit.
`include "alu3_params.svh"

package alu3_pkg;

	// ****************************************************************
	// Operation codes
	// ****************************************************************
	typedef enum logic [`ALU3_OP_W-1:0] {
		op_sum32_trap = 4'h0,
		op_sum32_wrap = 4'h1,
		op_diff32_trap = 4'h2,
		op_diff32_wrap = 4'h3,
		op_less_than_signed = 4'h4,
		op_less_than_unsigned = 4'h5,
		op_bitwise_conj = 4'h6,
		op_bitwise_disj = 4'h7,
		op_bitwise_exclusive = 4'h8,
		op_bitwise_not_any = 4'h9,
		op_wide_sum_trap = 4'ha,
		op_wide_sum_wrap = 4'hb,
		op_wide_diff_trap = 4'hc,
		op_wide_diff_wrap = 4'hd
	} alu3_op_t;

	// ****************************************************************
	// Registered state of the unit
	// ****************************************************************
	typedef struct packed {
		logic wb_valid;
		logic [`ALU3_IDX_W-1:0] wb_index;
		logic [`ALU3_XLEN-1:0] wb_data;
		logic ovf_exc;
		logic [`ALU3_IDX_W-1:0] exc_index;
	} alu3_state_t;

endpackage : alu3_pkg

/* alu3_adder.sv */
// Shared 64-bit adder and subtractor with overflow and compare flags.
`timescale 1ns/1ps
`include "alu3_params.svh"

module alu3_adder import alu3_pkg::*; (
	input logic [`ALU3_XLEN-1:0] a,
	input logic [`ALU3_XLEN-1:0] b,
	input logic sub,
	output logic [`ALU3_XLEN-1:0] result,
	output logic ovf_word,
	output logic ovf_dword,
	output logic lt_signed,
	output logic lt_unsigned
);

	// ****************************************************************
	// Two's complement overflow of one sign position
	// ****************************************************************
	function automatic logic ovf_at(input logic a_msb, input logic b_msb,
		input logic r_msb, input logic is_sub);
		logic b_eff;
		b_eff = b_msb ^ is_sub;
		ovf_at = (a_msb == b_eff) && (r_msb != a_msb);
	endfunction : ovf_at

	logic [`ALU3_XLEN:0] full;
	logic [`ALU3_XLEN-1:0] b_eff;

	// One carry chain serves both widths; the low word of the sum never depends on upper bits.
	always_comb begin
		b_eff = sub ? ~b : b;
		full = {1'b0, a} + {1'b0, b_eff} + {{`ALU3_XLEN{1'b0}}, sub};
		result = full[`ALU3_XLEN-1:0];
		ovf_word = ovf_at(a[`ALU3_WORD_MSB], b[`ALU3_WORD_MSB], result[`ALU3_WORD_MSB], sub);
		ovf_dword = ovf_at(a[`ALU3_DWORD_MSB], b[`ALU3_DWORD_MSB], result[`ALU3_DWORD_MSB], sub);
		lt_unsigned = ~full[`ALU3_XLEN];
		lt_signed = (a[`ALU3_DWORD_MSB] != b[`ALU3_DWORD_MSB]) ? a[`ALU3_DWORD_MSB] :
			result[`ALU3_DWORD_MSB];
	end

endmodule : alu3_adder

/* alu3_logic.sv */
// Bitwise operations of the three-operand integer unit.
`timescale 1ns/1ps
`include "alu3_params.svh"

module alu3_logic import alu3_pkg::*; (
	input logic [`ALU3_XLEN-1:0] a,
	input logic [`ALU3_XLEN-1:0] b,
	input alu3_op_t op,
	output logic [`ALU3_XLEN-1:0] result
);

	always_comb begin
		case (op)
			op_bitwise_conj: result = a & b;
			op_bitwise_disj: result = a | b;
			op_bitwise_exclusive: result = a ^ b;
			op_bitwise_not_any: result = ~(a | b);
			default: result = `ALU3_RST_DATA;
		endcase
	end

endmodule : alu3_logic

/* alu3_rf_model.sv */
// Register file model on the far side of the three-operand integer unit.
`timescale 1ns/1ps
`include "alu3_params.svh"

module alu3_rf_model import alu3_pkg::*; (
	input logic mclk,
	input logic [`ALU3_IDX_W-1:0] rf_a_index,
	input logic [`ALU3_IDX_W-1:0] rf_b_index,
	output logic [`ALU3_XLEN-1:0] rf_a_data,
	output logic [`ALU3_XLEN-1:0] rf_b_data,
	input logic wb_valid,
	input logic [`ALU3_IDX_W-1:0] wb_index,
	input logic [`ALU3_XLEN-1:0] wb_data,
	input logic load_en,
	input logic [`ALU3_IDX_W-1:0] load_index,
	input logic [`ALU3_XLEN-1:0] load_data
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [`ALU3_XLEN-1:0] regs [0:31];

	// Reads are asynchronous because the unit samples operands in the issue cycle.
	assign rf_a_data = regs[rf_a_index];
	assign rf_b_data = regs[rf_b_index];

	// A writeback and a bench preload may share an edge; the preload wins.
	always @(posedge mclk) begin
		if (wb_valid) begin
			regs[wb_index] <= wb_data;
		end
		if (load_en) begin
			regs[load_index] <= load_data;
		end
	end
endmodule : alu3_rf_model

/* three_operand_int_alu_tb.sv */
// Self-checking testbench of the three-operand integer unit.
`timescale 1ns/1ps
`include "alu3_params.svh"

module three_operand_int_alu_tb import alu3_pkg::*;;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic mode64 = 1'b1;
	logic issue_valid = 1'b0;
	alu3_op_t issue_op = op_sum32_wrap;
	logic [4:0] operand_a_index = 5'h01;
	logic [4:0] operand_b_index = 5'h02;
	logic [4:0] dest_index = 5'h03;
	logic [4:0] rf_a_index, rf_b_index, wb_index, exc_index;
	logic [63:0] rf_a_data, rf_b_data, wb_data;
	logic wb_valid, ovf_exc;
	logic load_en = 1'b0;
	logic [4:0] load_index = 5'h00;
	logic [63:0] load_data = 64'h0;
	int bad_count = 0;
	int comparisons = 0;

	always #2 mclk = ~mclk;

	alu3_unit dut (.mclk(mclk), .resetn(resetn), .ce(ce), .mode64(mode64),
		.issue_valid(issue_valid), .issue_op(issue_op), .operand_a_index(operand_a_index),
		.operand_b_index(operand_b_index), .dest_index(dest_index), .rf_a_index(rf_a_index),
		.rf_b_index(rf_b_index), .rf_a_data(rf_a_data), .rf_b_data(rf_b_data),
		.wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data), .ovf_exc(ovf_exc),
		.exc_index(exc_index));

	alu3_rf_model rfm (.mclk(mclk), .rf_a_index(rf_a_index), .rf_b_index(rf_b_index),
		.rf_a_data(rf_a_data), .rf_b_data(rf_b_data), .wb_valid(wb_valid),
		.wb_index(wb_index), .wb_data(wb_data), .load_en(load_en), .load_index(load_index),
		.load_data(load_data));

	// ****************************************************************
	// Compare tasks and reference
	// ****************************************************************
	task automatic chk_data(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_data

	task automatic chk_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	function automatic void exp_calc(input alu3_op_t op, input logic [63:0] a,
		input logic [63:0] b, input logic m64, output logic [63:0] e, output logic v);
		logic [31:0] w;
		w = a[31:0] + b[31:0];
		v = (a[31] == b[31]) && (w[31] != a[31]);
		if (op == op_diff32_trap || op == op_diff32_wrap) begin
			w = a[31:0] - b[31:0];
			v = (a[31] != b[31]) && (w[31] != a[31]);
		end
		e = {(m64 ? {32{w[31]}} : 32'h0), w};
		case (op)
			op_less_than_signed: e = {63'h0, $signed(a) < $signed(b)};
			op_less_than_unsigned: e = {63'h0, a < b};
			op_bitwise_conj: e = a & b;
			op_bitwise_disj: e = a | b;
			op_bitwise_exclusive: e = a ^ b;
			op_bitwise_not_any: e = ~(a | b);
			op_wide_sum_trap, op_wide_sum_wrap: e = a + b;
			op_wide_diff_trap, op_wide_diff_wrap: e = a - b;
			default: ;
		endcase
		if (op == op_wide_sum_trap) begin
			v = (a[63] == b[63]) && (e[63] != a[63]);
		end
		if (op == op_wide_diff_trap) begin
			v = (a[63] != b[63]) && (e[63] != a[63]);
		end
		// Only the four trapping codes may ever raise the exception.
		if (!(op inside {op_sum32_trap, op_diff32_trap, op_wide_sum_trap, op_wide_diff_trap})) begin
			v = 1'b0;
		end
	endfunction : exp_calc

	// Loads both sources and a marker into the destination, issues once, judges the answer.
	task automatic run_op(input alu3_op_t op, input logic [63:0] a, input logic [63:0] b,
		input logic m64);
		logic [63:0] e;
		logic v;
		exp_calc(op, a, b, m64, e, v);
		load_en = 1'b1;
		load_index = 5'h01;
		load_data = a;
		@(negedge mclk);
		load_index = 5'h02;
		load_data = b;
		@(negedge mclk);
		load_index = 5'h03;
		load_data = 64'h5a5a_a5a5_3c3c_c3c3;
		@(negedge mclk);
		load_en = 1'b0;
		mode64 = m64;
		issue_op = op;
		issue_valid = 1'b1;
		@(negedge mclk);
		issue_valid = 1'b0;
		chk_bit("wb_valid", !v, wb_valid);
		chk_bit("ovf_exc", v, ovf_exc);
		if (v) begin
			chk_data("exc_index", 64'h3, {59'h0, exc_index});
		end else begin
			chk_data("wb_data", e, wb_data);
			chk_data("wb_index", 64'h3, {59'h0, wb_index});
		end
		@(negedge mclk);
		chk_bit("wb_valid pulse end", 1'b0, wb_valid);
		chk_bit("ovf_exc pulse end", 1'b0, ovf_exc);
		chk_data("dest register", v ? 64'h5a5a_a5a5_3c3c_c3c3 : e, rfm.regs[3]);
	endtask : run_op

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic sc_sum32();
		run_op(op_sum32_wrap, 64'hffff_ffff_7fff_ffff, 64'h1234_5678_0000_0001, 1'b1);
		run_op(op_sum32_trap, 64'hffff_ffff_7fff_ffff, 64'h1234_5678_0000_0001, 1'b1);
		run_op(op_sum32_trap, 64'h0000_0000_8000_0000, 64'h0000_0000_8000_0000, 1'b1);
		run_op(op_sum32_trap, 64'h0000_0000_0000_0005, 64'h0000_0000_ffff_fffd, 1'b1);
	endtask : sc_sum32

	task automatic sc_diff32();
		run_op(op_diff32_trap, 64'h0000_0000_8000_0000, 64'h0000_0000_0000_0001, 1'b1);
		run_op(op_diff32_wrap, 64'h0000_0000_8000_0000, 64'h0000_0000_0000_0001, 1'b1);
		run_op(op_diff32_trap, 64'hdead_0000_0000_0003, 64'h0000_0000_0000_0005, 1'b1);
	endtask : sc_diff32

	task automatic sc_compare();
		run_op(op_less_than_signed, 64'hffff_ffff_ffff_ffff, 64'h1, 1'b1);
		run_op(op_less_than_unsigned, 64'hffff_ffff_ffff_ffff, 64'h1, 1'b1);
		run_op(op_less_than_signed, 64'h7, 64'h7, 1'b1);
		run_op(op_less_than_unsigned, 64'h1, 64'h8000_0000_0000_0000, 1'b1);
	endtask : sc_compare

	task automatic sc_logic();
		run_op(op_bitwise_conj, 64'hf0f0_0f0f_ff00_1234, 64'hff00_f0f0_0ff0_4321, 1'b1);
		run_op(op_bitwise_disj, 64'hf0f0_0f0f_ff00_1234, 64'hff00_f0f0_0ff0_4321, 1'b1);
		run_op(op_bitwise_exclusive, 64'hf0f0_0f0f_ff00_1234, 64'hff00_f0f0_0ff0_4321, 1'b1);
		run_op(op_bitwise_not_any, 64'hf0f0_0f0f_ff00_1234, 64'hff00_f0f0_0ff0_4321, 1'b1);
	endtask : sc_logic

	task automatic sc_wide();
		run_op(op_wide_sum_trap, 64'h7fff_ffff_ffff_ffff, 64'h1, 1'b1);
		run_op(op_wide_sum_wrap, 64'h7fff_ffff_ffff_ffff, 64'h1, 1'b1);
		run_op(op_wide_sum_trap, 64'h0000_0001_ffff_ffff, 64'h0000_0000_0000_0001, 1'b1);
		run_op(op_wide_diff_trap, 64'h8000_0000_0000_0000, 64'h1, 1'b1);
		run_op(op_wide_diff_wrap, 64'h8000_0000_0000_0000, 64'h1, 1'b1);
		run_op(op_wide_diff_trap, 64'h3, 64'h0000_0001_0000_0005, 1'b1);
	endtask : sc_wide

	task automatic sc_mode32();
		run_op(op_sum32_wrap, 64'h0000_0000_ffff_fff0, 64'h0000_0000_0000_0001, 1'b0);
		run_op(op_wide_sum_wrap, 64'h0000_0000_ffff_ffff, 64'h0000_0000_0000_0001, 1'b0);
	endtask : sc_mode32

	// Two issues on adjacent edges with fresh indices; neither may disturb the other.
	task automatic sc_back_to_back();
		load_en = 1'b1;
		load_index = 5'h04;
		load_data = 64'h0000_0000_0000_0009;
		@(negedge mclk);
		load_index = 5'h05;
		load_data = 64'h0000_0000_0000_0004;
		@(negedge mclk);
		load_en = 1'b0;
		mode64 = 1'b1;
		operand_a_index = 5'h04;
		operand_b_index = 5'h05;
		dest_index = 5'h06;
		issue_op = op_wide_sum_wrap;
		issue_valid = 1'b1;
		@(negedge mclk);
		operand_a_index = 5'h05;
		operand_b_index = 5'h04;
		dest_index = 5'h07;
		issue_op = op_wide_diff_wrap;
		chk_bit("wb_valid first", 1'b1, wb_valid);
		chk_data("wb_index first", 64'h6, {59'h0, wb_index});
		chk_data("wb_data first", 64'h0000_0000_0000_000d, wb_data);
		@(negedge mclk);
		issue_valid = 1'b0;
		operand_a_index = 5'h01;
		operand_b_index = 5'h02;
		dest_index = 5'h03;
		chk_bit("wb_valid second", 1'b1, wb_valid);
		chk_data("wb_index second", 64'h7, {59'h0, wb_index});
		chk_data("wb_data second", 64'hffff_ffff_ffff_fffb, wb_data);
		@(negedge mclk);
		chk_bit("wb_valid after pair", 1'b0, wb_valid);
		chk_bit("ovf_exc after pair", 1'b0, ovf_exc);
		chk_data("first dest register", 64'h0000_0000_0000_000d, rfm.regs[6]);
		chk_data("second dest register", 64'hffff_ffff_ffff_fffb, rfm.regs[7]);
	endtask : sc_back_to_back

	// An issue under a frozen clock enable and an unknown code must both be dropped.
	task automatic sc_refuse();
		ce = 1'b0;
		issue_op = op_wide_sum_wrap;
		issue_valid = 1'b1;
		@(negedge mclk);
		ce = 1'b1;
		issue_op = alu3_op_t'(4'he);
		chk_bit("wb_valid ce low", 1'b0, wb_valid);
		@(negedge mclk);
		issue_valid = 1'b0;
		chk_bit("wb_valid unknown op", 1'b0, wb_valid);
		chk_bit("ovf_exc unknown op", 1'b0, ovf_exc);
	endtask : sc_refuse

	// ****************************************************************
	// Sequence and verdict
	// ****************************************************************
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (12) @(negedge mclk);
		chk_bit("wb_valid in reset", 1'b0, wb_valid);
		chk_data("wb_data in reset", 64'h0, wb_data);
		resetn = 1'b1;
		sc_sum32();
		sc_diff32();
		sc_compare();
		sc_logic();
		sc_wide();
		sc_mode32();
		sc_back_to_back();
		sc_refuse();
		give_verdict();
	end

	// The run needs about 134 cycles; this limit leaves a wide margin.
	initial begin
		#20000;
		bad_count++;
		give_verdict();
	end
endmodule : three_operand_int_alu_tb
